// *** src/msc_pkg.sv ***
// Package: constants, layouts and carriers for the axis status and command port
// Overview of operation
// R1: Start command sets issued flag; stop clears.
// R2: First start pulse sets running; stop clears.
// R3: Stop interrupt flag, cleared by status read.
// R4: Start clears stopped flag; stop sets it.
// R5: Error flag clears on zero cause read.
// R6: Event flag clears on zero cause read.
// R7: Bits 6-7 show current sequence number.
// R8: Bits 8-12 show comparator hits.
// R9: Override reject flag, cleared by status read.
// R10: Bit 14 shows next-operation pre-register full.
// R11: Bit 15 shows comparator-5 pre-register full.
// R12: Sub bits 0-7 show terminal levels.
// R13: Sub bits 8-10 show speed phase.
// R14: Sub bits 11-14 show sensor inputs.
// R15: Sub bit 15 holds latched slow-down.
// R16: Correction pulses blank phase bits only.
// R17: Host writes combined select and command.
// R18: Host spaces commands four reference clocks.
// R19: Wait request stalls early host access.
// R20: Busy output low during post-command gap.
// R21: Register commands move buffer data.
// R22: Select bits or address pick axis.
// R23: Reset leaves flags clear, stopped set.
package msc_pkg;

   // Host address lines A2..A1
   localparam logic [1:0] ADDR_MAIN    = 2'h3;
   localparam logic [1:0] ADDR_SUB     = 2'h2;
   localparam logic [1:0] ADDR_BUF_LO  = 2'h1;
   localparam logic [1:0] ADDR_BUF_HI  = 2'h0;

   // Command word layout and code groups
   localparam int         CMD_CODE_LSB  = 0;
   localparam int         CMD_SEL_LSB   = 8;
   localparam int         NUM_AXES      = 4;
   localparam logic [7:0] START_MASK    = 8'hF8;
   localparam logic [7:0] START_BASE    = 8'h50;
   localparam logic [7:0] REG_GRP_MASK  = 8'hC0;
   localparam logic [7:0] REG_WR_BASE   = 8'h80;
   localparam logic [7:0] REG_RD_BASE   = 8'hC0;
   localparam logic [7:0] REG_IDX_MASK  = 8'h3F;

   // Post-command gap, counted in reference clocks (this clock)
   localparam int         GAP_REF_CLK   = 4;
   localparam logic [2:0] GAP_CYC       = 3'(GAP_REF_CLK);
   localparam logic [2:0] GAP_ZERO      = 3'h0;
   localparam logic [2:0] GAP_STEP      = 3'h1;

   typedef struct packed {
      logic       cmp5_prereg_full;
      logic       next_op_prereg_full;
      logic       override_reject_flag;
      logic [4:0] comparator_hit_flag;
      logic [1:0] sequence_number_field;
      logic       event_summary_flag;
      logic       error_summary_flag;
      logic       stopped_flag;
      logic       stop_interrupt_flag;
      logic       running_flag;
      logic       command_issued_flag;
   } msc_main_status_t;

   typedef struct packed {
      logic       slowdown_latched_flag;
      logic       origin_active_flag;
      logic       minus_limit_flag;
      logic       plus_limit_flag;
      logic       alarm_active_flag;
      logic       constant_speed_flag;
      logic       decelerating_flag;
      logic       accelerating_flag;
      logic [7:0] gp_terminal_level;
   } msc_sub_status_t;

   // Events and levels from the pulse generator and cause registers
   typedef struct packed {
      logic       start_pulse;
      logic       op_stop;
      logic       error_irq;
      logic       event_irq;
      logic       error_cause_read;
      logic       error_cause_zero;
      logic       event_cause_read;
      logic       event_cause_zero;
      logic       move_amount_write;
      logic [1:0] seq_num;
      logic [4:0] cmp_hit;
      logic       next_op_prereg_full;
      logic       cmp5_prereg_full;
   } msc_core_evt_t;

   // Sensor and phase levels
   typedef struct packed {
      logic       accel;
      logic       decel;
      logic       constant;
      logic       correction;
      logic       alarm_input;
      logic       plus_end_limit_input;
      logic       minus_end_limit_input;
      logic       origin_input;
      logic       slowdown_input;
      logic [7:0] gp_level;
   } msc_sense_t;

   localparam msc_main_status_t MAIN_RESET = 16'h0008;
   localparam msc_sub_status_t  SUB_RESET  = 16'h0000;
   localparam logic [7:0]       GP_RESET   = 8'h00;
   localparam logic [31:0]      BUF_RESET  = 32'h0000_0000;

endpackage : msc_pkg

// *** src/msc_status_port.sv ***
// Module: per-axis status words, command decode, transfer buffer and access pacing
`timescale 1ns/100ps

module msc_status_port
   import msc_pkg::*;
#(
   parameter logic [1:0] AXIS_IDX = 2'h0
)
(
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   // Host parallel bus
   input  wire logic              cs_n_i,
   input  wire logic              rd_n_i,
   input  wire logic              wr_n_i,
   input  wire logic [1:0]        addr_i,
   input  wire logic [1:0]        axis_addr_i,
   input  wire logic [15:0]       data_i,
   output logic [15:0]            data_o,
   output logic                   data_oe_n_o,
   output logic                   wait_request_n_o,
   output logic                   interface_busy_n_o,
   // Environment settings
   input  wire logic              stop_interrupt_enable_i,
   input  wire logic              status_hold_setting_i,
   // Core events and sensor levels
   input  wire msc_core_evt_t     core_i,
   input  wire msc_sense_t        sense_i,
   // Command and register transfer to the core
   output logic                   start_cmd_o,
   output logic [7:0]             cmd_code_o,
   output logic                   cmd_exec_o,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o,
   output logic [5:0]             reg_idx_o,
   output logic [31:0]            reg_wdata_o,
   input  wire logic [31:0]       reg_rdata_i,
   // Status outputs
   output logic                   stop_irq_o,
   output logic [7:0]             gp_out_o
);

   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_WAIT,
      ACC_HOLD
   } msc_acc_state_t;

   msc_acc_state_t   acc_state_q;
   msc_main_status_t main_q;
   msc_sub_status_t  sub_q;
   logic [31:0]      buf_q;
   logic [2:0]       gap_cnt_q;
   logic [2:0]       gap_cnt_d;
   logic [15:0]      data_q;
   logic             data_oe_n_q;
   logic             wrq_n_q;
   logic             ifb_n_q;
   logic             start_q;
   logic             exec_q;
   logic             reg_wr_q;
   logic             reg_rd_q;
   logic [7:0]       code_q;
   logic [7:0]       gp_out_q;
   logic             stop_irq_q;

   logic             access;
   logic             is_rd;
   logic             busy;
   logic             take;
   logic             take_wr;
   logic             take_rd;
   logic             cmd_wr;
   logic [7:0]       cmd_code;
   logic [3:0]       cmd_sel;
   logic             axis_hit;
   logic             start_hit;
   logic             main_read;
   logic             sub_read;
   logic             operating;

   assign access    = !cs_n_i && (!rd_n_i || !wr_n_i);
   assign is_rd     = !rd_n_i;
   assign busy      = (gap_cnt_q != GAP_ZERO);
   // A new access is taken only once the post-command gap has run out
   assign take      = access && (acc_state_q != ACC_HOLD) && !busy; // R19
   assign take_wr   = take && !is_rd;
   assign take_rd   = take && is_rd;
   assign cmd_wr    = take_wr && (addr_i == ADDR_MAIN); // R17
   assign cmd_code  = data_i[CMD_CODE_LSB +: 8];
   assign cmd_sel   = data_i[CMD_SEL_LSB +: NUM_AXES];
   // No select bit set: the axis named by the upper address lines runs it
   assign axis_hit  = (cmd_sel == '0) ? (axis_addr_i == AXIS_IDX)
                                      : cmd_sel[AXIS_IDX]; // R22
   assign start_hit = cmd_wr && axis_hit
                      && ((cmd_code & START_MASK) == START_BASE);
   assign main_read = take_rd && (addr_i == ADDR_MAIN);
   assign sub_read  = take_rd && (addr_i == ADDR_SUB);
   assign operating = !main_q.stopped_flag;

   // Host access sequencing
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         acc_state_q <= ACC_IDLE;
      end
      else
      begin
         unique case (acc_state_q)
            ACC_IDLE, ACC_WAIT:
            begin
               if (take)
               begin
                  acc_state_q <= ACC_HOLD;
               end
               else if (access)
               begin
                  acc_state_q <= ACC_WAIT;
               end
               else
               begin
                  acc_state_q <= ACC_IDLE;
               end
            end
            ACC_HOLD:
            begin
               if (!access)
               begin
                  acc_state_q <= ACC_IDLE;
               end
            end
         endcase
      end
   end

   // Gap counter restarts on every command write
   always_comb
   begin
      if (cmd_wr)
      begin
         gap_cnt_d = GAP_CYC; // R18
      end
      else if (busy)
      begin
         gap_cnt_d = gap_cnt_q - GAP_STEP;
      end
      else
      begin
         gap_cnt_d = GAP_ZERO;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         gap_cnt_q <= GAP_ZERO;
         ifb_n_q   <= 1'b1;
         wrq_n_q   <= 1'b1;
      end
      else
      begin
         gap_cnt_q <= gap_cnt_d;
         ifb_n_q   <= (gap_cnt_d == GAP_ZERO); // R20
         // Stall a host cycle that arrives inside the gap
         wrq_n_q   <= !(access && busy && (acc_state_q != ACC_HOLD)
                        && (gap_cnt_d != GAP_ZERO)); // R19
      end
   end

   // Read data is frozen at take so the host sees a stable word
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         data_q      <= 16'h0000;
         data_oe_n_q <= 1'b1;
      end
      else
      begin
         if (take_rd)
         begin
            unique case (addr_i)
               ADDR_MAIN:   data_q <= main_q;
               ADDR_SUB:    data_q <= sub_q;
               ADDR_BUF_LO: data_q <= buf_q[15:0];
               ADDR_BUF_HI: data_q <= buf_q[31:16];
            endcase
         end
         data_oe_n_q <= !(access && is_rd && ((acc_state_q == ACC_HOLD) || take_rd));
      end
   end

   // Transfer buffer: host halves, or loaded by a register read command
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         buf_q <= BUF_RESET;
      end
      else if (reg_rd_q)
      begin
         buf_q <= reg_rdata_i; // R21
      end
      else if (take_wr && (addr_i == ADDR_BUF_LO))
      begin
         buf_q[15:0] <= data_i;
      end
      else if (take_wr && (addr_i == ADDR_BUF_HI))
      begin
         buf_q[31:16] <= data_i;
      end
   end

   // Command decode to the core
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         start_q  <= 1'b0;
         exec_q   <= 1'b0;
         reg_wr_q <= 1'b0;
         reg_rd_q <= 1'b0;
         code_q   <= 8'h00;
      end
      else
      begin
         start_q  <= start_hit;
         exec_q   <= cmd_wr && axis_hit;
         reg_wr_q <= cmd_wr && axis_hit
                     && ((cmd_code & REG_GRP_MASK) == REG_WR_BASE); // R21
         reg_rd_q <= cmd_wr && axis_hit
                     && ((cmd_code & REG_GRP_MASK) == REG_RD_BASE); // R21
         if (cmd_wr && axis_hit)
         begin
            code_q <= cmd_code;
         end
      end
   end

   // General-purpose output port write
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         gp_out_q <= GP_RESET;
      end
      else if (take_wr && (addr_i == ADDR_SUB))
      begin
         gp_out_q <= data_i[7:0];
      end
   end

   // Run state flags
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         main_q.command_issued_flag <= MAIN_RESET.command_issued_flag; // R23
         main_q.running_flag        <= MAIN_RESET.running_flag;
         main_q.stopped_flag        <= MAIN_RESET.stopped_flag;
      end
      else
      begin
         // A stop in the same cycle as a new start leaves the axis started
         if (start_hit)
         begin
            main_q.command_issued_flag <= 1'b1; // R1
            main_q.stopped_flag        <= 1'b0; // R4
         end
         else if (core_i.op_stop)
         begin
            main_q.command_issued_flag <= 1'b0; // R1
            main_q.stopped_flag        <= 1'b1; // R4
         end
         if (core_i.start_pulse)
         begin
            main_q.running_flag <= 1'b1; // R2
         end
         else if (core_i.op_stop)
         begin
            main_q.running_flag <= 1'b0; // R2
         end
      end
   end

   // Sticky event flags; a set wins over a read clear in the same cycle
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         main_q.stop_interrupt_flag  <= MAIN_RESET.stop_interrupt_flag;
         main_q.override_reject_flag <= MAIN_RESET.override_reject_flag;
         main_q.error_summary_flag   <= MAIN_RESET.error_summary_flag;
         main_q.event_summary_flag   <= MAIN_RESET.event_summary_flag;
         stop_irq_q                  <= 1'b0;
      end
      else
      begin
         if (!stop_interrupt_enable_i)
         begin
            main_q.stop_interrupt_flag <= 1'b0; // R3
         end
         else if (core_i.op_stop && operating)
         begin
            main_q.stop_interrupt_flag <= 1'b1; // R3
         end
         else if (main_read && !status_hold_setting_i)
         begin
            main_q.stop_interrupt_flag <= 1'b0; // R3
         end
         stop_irq_q <= stop_interrupt_enable_i && core_i.op_stop && operating; // R3
         if (core_i.move_amount_write && !operating)
         begin
            main_q.override_reject_flag <= 1'b1; // R9
         end
         else if (main_read && !status_hold_setting_i)
         begin
            main_q.override_reject_flag <= 1'b0; // R9
         end
         if (core_i.error_irq)
         begin
            main_q.error_summary_flag <= 1'b1; // R5
         end
         else if (core_i.error_cause_read && core_i.error_cause_zero)
         begin
            main_q.error_summary_flag <= 1'b0; // R5
         end
         if (core_i.event_irq)
         begin
            main_q.event_summary_flag <= 1'b1; // R6
         end
         else if (core_i.event_cause_read && core_i.event_cause_zero)
         begin
            main_q.event_summary_flag <= 1'b0; // R6
         end
      end
   end

   // Level fields of the main status word
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         main_q.sequence_number_field <= MAIN_RESET.sequence_number_field;
         main_q.comparator_hit_flag   <= MAIN_RESET.comparator_hit_flag;
         main_q.next_op_prereg_full   <= MAIN_RESET.next_op_prereg_full;
         main_q.cmp5_prereg_full      <= MAIN_RESET.cmp5_prereg_full;
      end
      else
      begin
         main_q.sequence_number_field <= core_i.seq_num; // R7
         main_q.comparator_hit_flag   <= core_i.cmp_hit; // R8
         main_q.next_op_prereg_full   <= core_i.next_op_prereg_full; // R10
         main_q.cmp5_prereg_full      <= core_i.cmp5_prereg_full; // R11
      end
   end

   // Sub status word
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         sub_q <= SUB_RESET;
      end
      else
      begin
         sub_q.gp_terminal_level     <= sense_i.gp_level; // R12
         // Correction pulses blank the phase bits; running stays set
         sub_q.accelerating_flag     <= sense_i.accel && !sense_i.correction; // R13 R16
         sub_q.decelerating_flag     <= sense_i.decel && !sense_i.correction; // R13 R16
         sub_q.constant_speed_flag   <= sense_i.constant && !sense_i.correction; // R13 R16
         sub_q.alarm_active_flag     <= sense_i.alarm_input; // R14
         sub_q.plus_limit_flag       <= sense_i.plus_end_limit_input; // R14
         sub_q.minus_limit_flag      <= sense_i.minus_end_limit_input; // R14
         sub_q.origin_active_flag    <= sense_i.origin_input; // R14
         // Latched so a short slow-down pulse is not missed by polling
         if (sense_i.slowdown_input)
         begin
            sub_q.slowdown_latched_flag <= 1'b1; // R15
         end
         else if (sub_read)
         begin
            sub_q.slowdown_latched_flag <= 1'b0; // R15
         end
      end
   end

   assign data_o             = data_q;
   assign data_oe_n_o        = data_oe_n_q;
   assign wait_request_n_o   = wrq_n_q;
   assign interface_busy_n_o = ifb_n_q;
   assign start_cmd_o        = start_q;
   assign cmd_code_o         = code_q;
   assign cmd_exec_o         = exec_q;
   assign reg_wr_o           = reg_wr_q;
   assign reg_rd_o           = reg_rd_q;
   assign reg_idx_o          = 6'(code_q & REG_IDX_MASK);
   assign reg_wdata_o        = buf_q;
   assign stop_irq_o         = stop_irq_q;
   assign gp_out_o           = gp_out_q;

endmodule : msc_status_port

// *** dv/msc_status_port_asserts.sv ***
// Checker: timing properties on the status port pins
`timescale 1ns/100ps
module msc_status_port_asserts
   import msc_pkg::*;
#(
   parameter logic [1:0] AXIS_IDX = 2'h0
)
(
   // Clock and reset
   input  wire logic          core_clk_i,
   input  wire logic          rstn_i,
   // Host bus
   input  wire logic          cs_n_i,
   input  wire logic          rd_n_i,
   input  wire logic          data_oe_n_o,
   input  wire logic          wait_request_n_o,
   input  wire logic          interface_busy_n_o,
   // Core side
   input  wire logic          stop_interrupt_enable_i,
   input  wire msc_core_evt_t core_i,
   input  wire logic          start_cmd_o,
   input  wire logic [7:0]    cmd_code_o,
   input  wire logic          cmd_exec_o,
   input  wire logic          reg_wr_o,
   input  wire logic          reg_rd_o,
   input  wire logic [5:0]    reg_idx_o,
   input  wire logic          stop_irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   reset_idle_a: assert property (disable iff (1'b0)
      !rstn_i |=> wait_request_n_o && interface_busy_n_o && data_oe_n_o)
      else $error("bus outputs not idle after reset");
   busy_gap_a: assert property ($fell(interface_busy_n_o) |->
      !interface_busy_n_o [*4] ##1 interface_busy_n_o)
      else $error("busy gap is not four clocks");
   wait_in_gap_a: assert property ($fell(wait_request_n_o) |->
      !$past(interface_busy_n_o)) else $error("stall outside the gap");
   wait_bound_a: assert property ($fell(wait_request_n_o) |->
      ##[1:6] wait_request_n_o) else $error("stall held too long");
   start_code_a: assert property (start_cmd_o |-> cmd_exec_o &&
      ((cmd_code_o & START_MASK) == START_BASE)) else $error("start on wrong code");
   start_pulse_a: assert property (start_cmd_o |=> !start_cmd_o)
      else $error("start pulse too long");
   exec_busy_a: assert property (cmd_exec_o |-> !interface_busy_n_o)
      else $error("command without busy gap");
   reg_write_a: assert property (reg_wr_o |-> cmd_exec_o &&
      ((cmd_code_o & REG_GRP_MASK) == REG_WR_BASE) && (reg_idx_o == cmd_code_o[5:0]))
      else $error("bad register write command");
   reg_read_a: assert property (reg_rd_o |-> cmd_exec_o &&
      ((cmd_code_o & REG_GRP_MASK) == REG_RD_BASE) && (reg_idx_o == cmd_code_o[5:0]))
      else $error("bad register read command");
   stop_irq_a: assert property (stop_irq_o |->
      $past(core_i.op_stop && stop_interrupt_enable_i)) else $error("stray stop interrupt");
endmodule : msc_status_port_asserts

bind msc_status_port msc_status_port_asserts #(.AXIS_IDX(AXIS_IDX)) u_chk (
   .core_clk_i, .rstn_i, .cs_n_i, .rd_n_i, .data_oe_n_o, .wait_request_n_o,
   .interface_busy_n_o, .stop_interrupt_enable_i, .core_i, .start_cmd_o, .cmd_code_o,
   .cmd_exec_o, .reg_wr_o, .reg_rd_o, .reg_idx_o, .stop_irq_o);

// *** dv/msc_host_model.sv ***
// Host model: parallel bus master that honours the post-command gap
`timescale 1ns/100ps
module msc_host_model
(
   // Clock
   input  wire logic        core_clk_i,
   // Bus pins
   output logic             cs_n_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic [1:0]       addr_o,
   output logic [15:0]      data_o,
   input  wire logic [15:0] data_i,
   input  wire logic        data_oe_n_i,
   input  wire logic        wait_request_n_i
);
   int stalls = 0;

   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 2'h0;
      data_o = 16'h0000;
   end

   // Whole 16-bit word per access, select and code together
   task automatic xfer(input logic wr, input logic [1:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      int n;
      int hi;
      n = 0;
      hi = 0;
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      addr_o <= a;
      rd_n_o <= wr;
      wr_n_o <= !wr;
      if (wr) data_o <= d;
      // Two clear edges needed: stall may lift one edge before the take
      do
      begin
         @(posedge core_clk_i);
         n++;
         hi = wait_request_n_i ? hi + 1 : 0;
         stalls += !wait_request_n_i;
      end
      while (n < 60 && !(n >= 2 && hi >= 2 && (wr || !data_oe_n_i)));
      q = data_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      data_o <= ~data_o;
   endtask : xfer
endmodule : msc_host_model

// *** dv/tb_top.sv ***
// Testbench: status words, command pacing and register transfer
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top
   import msc_pkg::*;
;
   localparam logic [15:0] SEL_CMD [4] = '{16'h0200, 16'h0100, 16'h0000, 16'h0000};
   localparam logic [1:0]  SEL_AX  [4] = '{2'h0, 2'h1, 2'h1, 2'h0};
   localparam int          SEL_INC [4] = '{0, 1, 0, 1};
   logic          clk = 1'b0;
   logic          rst_n, cs_n, rd_n, wr_n, oe_n, wait_n, busy_n, sie, hold;
   logic          start, exec, regwr, regrd, irq;
   logic [1:0]    addr, axis_addr;
   logic [15:0]   wdata, rdata, hq;
   logic [7:0]    code, gp;
   logic [5:0]    idx, cap_idx;
   logic [31:0]   wd, cap_wd, rdreg;
   msc_core_evt_t core;
   msc_sense_t    sense;
   int            fail_count = 0, n_checks = 0, starts = 0, execs = 0, irqs = 0;
   int            cyc = 0, s, e;

   msc_status_port #(.AXIS_IDX(2'h0)) dut (.core_clk_i(clk), .rstn_i(rst_n), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .axis_addr_i(axis_addr), .data_i(wdata),
      .data_o(rdata), .data_oe_n_o(oe_n), .wait_request_n_o(wait_n),
      .interface_busy_n_o(busy_n), .stop_interrupt_enable_i(sie),
      .status_hold_setting_i(hold), .core_i(core), .sense_i(sense), .start_cmd_o(start),
      .cmd_code_o(code), .cmd_exec_o(exec), .reg_wr_o(regwr), .reg_rd_o(regrd),
      .reg_idx_o(idx), .reg_wdata_o(wd), .reg_rdata_i(rdreg), .stop_irq_o(irq), .gp_out_o(gp));
   msc_host_model u_host (.core_clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .addr_o(addr), .data_o(wdata), .data_i(rdata), .data_oe_n_i(oe_n),
      .wait_request_n_i(wait_n));

   initial
   begin
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      starts <= starts + start;
      execs <= execs + exec;
      irqs <= irqs + irq;
      if (regwr) cap_wd <= wd;
      if (regwr) cap_idx <= idx;
      cyc <= cyc + 1;
      // Whole sequence needs well under a thousand clocks
      if (cyc == 3000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic rd(input logic [1:0] a, input logic [15:0] x);
      logic [15:0] q;
      u_host.xfer(1'b0, a, 16'h0000, q);
      `CHK(q, x)
   endtask : rd

   // Extra edge lets the command pulses land in the counters
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      logic [15:0] q;
      u_host.xfer(1'b1, a, d, q);
      @(posedge clk);
      #1;
   endtask : wr

   task automatic evt(input msc_core_evt_t m);
      @(posedge clk);
      core <= msc_core_evt_t'(core | m);
      @(posedge clk);
      core <= msc_core_evt_t'(core & ~m);
      @(posedge clk);
      #1;
   endtask : evt

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   initial
   begin
      rst_n = 1'b0;
      sie = 1'b0;
      hold = 1'b0;
      axis_addr = 2'h0;
      rdreg = 32'h5A5A_0F0F;
      core = '0;
      sense = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK({wait_n, busy_n, oe_n}, 3'h7)
      rd(ADDR_MAIN, 16'h0008);
      core <= '{seq_num: 2'h2, cmp_hit: 5'h15, next_op_prereg_full: 1'b1, default: '0};
      sie <= 1'b1;
      // No trailing edge here, so the next read lands inside the gap
      u_host.xfer(1'b1, ADDR_MAIN, 16'h0050, hq);
      #1;
      `CHK(busy_n, 1'b0)
      `CHK(starts, 1)
      s = u_host.stalls;
      rd(ADDR_MAIN, 16'h5581);
      `CHK(u_host.stalls > s, 1'b1)
      evt('{start_pulse: 1'b1, default: '0});
      rd(ADDR_MAIN, 16'h5583);
      evt('{op_stop: 1'b1, default: '0});
      `CHK(irqs, 1)
      rd(ADDR_MAIN, 16'h558C);
      rd(ADDR_MAIN, 16'h5588);
      hold <= 1'b1;
      evt('{move_amount_write: 1'b1, default: '0});
      rd(ADDR_MAIN, 16'h7588);
      rd(ADDR_MAIN, 16'h7588);
      hold <= 1'b0;
      rd(ADDR_MAIN, 16'h7588);
      rd(ADDR_MAIN, 16'h5588);
      evt('{error_irq: 1'b1, event_irq: 1'b1, default: '0});
      evt('{error_cause_read: 1'b1, default: '0});
      rd(ADDR_MAIN, 16'h55B8);
      core <= '{seq_num: 2'h2, cmp_hit: 5'h15, cmp5_prereg_full: 1'b1,
                error_cause_zero: 1'b1, event_cause_zero: 1'b1, default: '0};
      evt('{error_cause_read: 1'b1, event_cause_read: 1'b1, default: '0});
      rd(ADDR_MAIN, 16'h9588);
      sie <= 1'b0;
      wr(ADDR_MAIN, 16'h0050);
      evt('{op_stop: 1'b1, default: '0});
      rd(ADDR_MAIN, 16'h9588);
      `CHK(irqs, 1)
      sense <= '{accel: 1'b1, alarm_input: 1'b1, origin_input: 1'b1, slowdown_input: 1'b1,
                 gp_level: 8'hA5, default: '0};
      rd(ADDR_SUB, 16'hC9A5);
      sense <= '{decel: 1'b1, correction: 1'b1, plus_end_limit_input: 1'b1,
                 minus_end_limit_input: 1'b1, gp_level: 8'h5A, default: '0};
      rd(ADDR_SUB, 16'hB05A);
      rd(ADDR_SUB, 16'h305A);
      sense <= '{constant: 1'b1, plus_end_limit_input: 1'b1, minus_end_limit_input: 1'b1,
                 gp_level: 8'h5A, default: '0};
      rd(ADDR_SUB, 16'h345A);
      wr(ADDR_SUB, 16'h00C3);
      `CHK(gp, 8'hC3)
      wr(ADDR_BUF_LO, 16'h1234);
      wr(ADDR_BUF_HI, 16'hABCD);
      rd(ADDR_BUF_HI, 16'hABCD);
      wr(ADDR_MAIN, 16'h0081);
      `CHK({cap_idx, cap_wd}, {6'h01, 32'hABCD_1234})
      wr(ADDR_MAIN, 16'h00C2);
      rd(ADDR_BUF_LO, 16'h0F0F);
      rd(ADDR_BUF_HI, 16'h5A5A);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         axis_addr <= SEL_AX[i];
         e = execs;
         wr(ADDR_MAIN, SEL_CMD[i]);
         `CHK(execs - e, SEL_INC[i])
      end
      report_and_stop();
   end
endmodule : tb_top
